// ---- hw/atr_pkg.sv ----
package atr_pkg;

	// register indices within the readout block
	localparam logic [3:0] ACCEL_X_HIGH_IDX = 4'h0;
	localparam logic [3:0] ACCEL_X_LOW_IDX  = 4'h1;
	localparam logic [3:0] ACCEL_Y_HIGH_IDX = 4'h2;
	localparam logic [3:0] ACCEL_Y_LOW_IDX  = 4'h3;
	localparam logic [3:0] ACCEL_Z_HIGH_IDX = 4'h4;
	localparam logic [3:0] ACCEL_Z_LOW_IDX  = 4'h5;
	localparam logic [3:0] TEMP_HIGH_IDX    = 4'h6;
	localparam logic [3:0] TEMP_LOW_IDX     = 4'h7;

	// data widths and field positions
	localparam int ACCEL_BITS     = 14;
	localparam int ACCEL_LSB_POS  = 2;
	localparam int TEMP_BITS      = 13;
	localparam int TEMP_LSB_POS   = 1;
	localparam int AXIS_COUNT     = 3;

	// scale figures, for reference by software models
	localparam int ACCEL_COUNTS_PER_G = 650;
	localparam int TEMP_COUNTS_AT_23C = 4096;

	// values after reset
	localparam logic [7:0]  READ_DATA_RST  = 8'h00;
	localparam logic [15:0] WORD_RST       = 16'h0000;
	localparam logic [7:0]  TEMP_LATCH_RST = 8'h00;

	typedef enum logic [1:0] {
		ATR_IDLE,
		ATR_READ
	} atr_state_t;

endpackage

// ---- hw/atr_word_pack.sv ----
`timescale 1ns/100ps
// places a sample field into a 16-bit register word; unused bits are zero
module atr_word_pack #(
	parameter int FIELD_BITS = 14,
	parameter int FIELD_POS  = 2
) (
	input  wire logic [FIELD_BITS-1:0] field,
	output wire logic [15:0]           word
);
	localparam int TOP_GAP = 16 - FIELD_BITS - FIELD_POS;

	// sign fill above is done by caller through field width choice; any gap left above the field is zeroed here
	if (TOP_GAP > 0) begin : gTop
		assign word[15:FIELD_BITS+FIELD_POS] = '0;
	end
	assign word[FIELD_BITS+FIELD_POS-1:FIELD_POS] = field;
	if (FIELD_POS > 0) begin : gLow
		assign word[FIELD_POS-1:0] = '0;
	end
endmodule

// ---- hw/atr_readout.sv ----
`timescale 1ns/100ps
// Summary of operation
// [RULE1] each axis sample is 14-bit two's complement over a high and low byte
// [RULE2] sample sits in bits 15:2; bits 1:0 zero; bits 15 and 14 both sign
// [RULE3] host joins bytes and shifts right arithmetically by two
// [RULE4] one g equals 650 counts after shift, about 1.54 mg per count
// [RULE5] temperature is 13-bit unsigned in bits 13:1; bits 15,14,0 unused
// [RULE6] temperature high-byte read latches the low byte; host reads high first
// [RULE7] temperature typically reads 4096 at 23 C, about 25.6 counts per degree
// [RULE8] host masks unused bit positions before computing values
module atr_readout (
	input  wire logic                              ref_clk,
	input  wire logic                              rstn,
	input  wire logic [atr_pkg::AXIS_COUNT*atr_pkg::ACCEL_BITS-1:0] accelSamples,
	input  wire logic [atr_pkg::TEMP_BITS-1:0]     tempSample,
	input  wire logic                              sampleValid,
	input  wire logic                              readStrobe,
	input  wire logic [3:0]                        readIndex,
	output logic [7:0]                             readData_r,
	output logic                                   readValid_r
);
	import atr_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// sample capture: hold words stable between conversions
	logic [15:0] accelWord_r [AXIS_COUNT];
	logic [15:0] tempWord_r;
	logic [15:0] accelPacked [AXIS_COUNT];
	logic [15:0] tempPacked;
	logic [7:0]  tempLowLatch_r;
	logic [7:0]  readMux;
	logic        tempHighRead;
	logic        indexMapped;

	// [RULE1] two's complement axis
	// [RULE2] sign in 15 and 14
	// [RULE4] counts passed unscaled
	// an input beyond the 13-bit span would split bits 15 and 14, so it is clamped
	// to the nearest end; the converter should never get there, this only keeps
	// the doubled sign true if it does
	for (genvar a = 0; a < AXIS_COUNT; a++) begin : gAxis
		logic [ACCEL_BITS-1:0] rawAxis;
		logic                  signBit;
		logic                  overRange;
		logic [ACCEL_BITS-1:0] clampAxis;
		assign rawAxis   = accelSamples[a*ACCEL_BITS +: ACCEL_BITS];
		assign signBit   = rawAxis[ACCEL_BITS-1];
		assign overRange = signBit != rawAxis[ACCEL_BITS-2];
		assign clampAxis = overRange
			? {signBit, signBit, {(ACCEL_BITS-2){~signBit}}}
			: rawAxis;
		atr_word_pack #(
			.FIELD_BITS(ACCEL_BITS),
			.FIELD_POS (ACCEL_LSB_POS)
		) uPack (
			.field(clampAxis),
			.word (accelPacked[a])
		);
	end

	// [RULE5] temperature field at 13:1
	// [RULE7] counts passed unscaled
	atr_word_pack #(
		.FIELD_BITS(TEMP_BITS),
		.FIELD_POS (TEMP_LSB_POS)
	) uTempPack (
		.field(tempSample),
		.word (tempPacked)
	);

	// words update only when a new conversion arrives
	// a read in the same cycle still sees the old words; only the temperature pair is kept from mixing samples, by the latch
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			for (int i = 0; i < AXIS_COUNT; i++) accelWord_r[i] <= WORD_RST;
			tempWord_r <= WORD_RST;
		end else if (sampleValid) begin
			for (int i = 0; i < AXIS_COUNT; i++) accelWord_r[i] <= accelPacked[i];
			tempWord_r <= tempPacked;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read decode
	assign tempHighRead = readStrobe && (readIndex == TEMP_HIGH_IDX);
	assign indexMapped  = (readIndex <= TEMP_LOW_IDX);

	// the latch takes the held word, the same one the high byte is read from
	// [RULE6] low byte frozen by high read
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			tempLowLatch_r <= TEMP_LATCH_RST;
		end else if (tempHighRead) begin
			tempLowLatch_r <= tempWord_r[7:0];
		end
	end

	// unmapped indices read zero; temp low comes from the latch, not live data
	always_comb begin
		readMux = READ_DATA_RST;
		case (readIndex)
			ACCEL_X_HIGH_IDX: readMux = accelWord_r[0][15:8];
			ACCEL_X_LOW_IDX:  readMux = accelWord_r[0][7:0];
			ACCEL_Y_HIGH_IDX: readMux = accelWord_r[1][15:8];
			ACCEL_Y_LOW_IDX:  readMux = accelWord_r[1][7:0];
			ACCEL_Z_HIGH_IDX: readMux = accelWord_r[2][15:8];
			ACCEL_Z_LOW_IDX:  readMux = accelWord_r[2][7:0];
			TEMP_HIGH_IDX:    readMux = tempWord_r[15:8];
			TEMP_LOW_IDX:     readMux = tempLowLatch_r;
			default:          readMux = READ_DATA_RST;
		endcase
	end

	// read answer one cycle after the strobe
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			readData_r  <= READ_DATA_RST;
			readValid_r <= 1'b0;
		end else begin
			readData_r  <= (readStrobe && indexMapped) ? readMux : READ_DATA_RST;
			readValid_r <= readStrobe;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	// range flags of the X and Y inputs; the placement checks split on them
	logic xInRange;
	logic yInRange;
	assign xInRange = accelSamples[ACCEL_BITS-1] == accelSamples[ACCEL_BITS-2];
	assign yInRange = accelSamples[2*ACCEL_BITS-1] == accelSamples[2*ACCEL_BITS-2];

	sequence tempHighSeen;
		readStrobe && readIndex == TEMP_HIGH_IDX;
	endsequence

	sequence tempLowNext;
		readStrobe && readIndex == TEMP_LOW_IDX;
	endsequence

	// high read, a cycle with no second high read, then low read: the low answer is
	// the low half as it stood at the high read, even if a conversion landed between
	property tempPairHold;
		@(posedge ref_clk) disable iff (!rstn)
		tempHighSeen ##1 !tempHighRead ##1 tempLowNext
			|=> readData_r == $past(tempWord_r[7:0], 3);
	endproperty

	temp_pair_a: assert property (tempPairHold) // [RULE6]
		else $error("temperature low byte not the latched half");

	low_from_latch_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE6]
		tempLowNext |=> readValid_r && readData_r == $past(tempLowLatch_r))
		else $error("temperature low byte not taken from the latch");

	latch_capture_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE6]
		tempHighSeen |=> tempLowLatch_r == $past(tempWord_r[7:0]))
		else $error("temperature low byte not latched on high read");

	// the latch may only move on a high read, or a later low read sees a new half
	latch_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE6]
		!tempHighRead |=> $stable(tempLowLatch_r))
		else $error("temperature latch moved without a high read");

	accel_sign_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE2]
		accelWord_r[0][15] == accelWord_r[0][14] && accelWord_r[0][1:0] == 2'h0)
		else $error("axis word sign or low bits wrong");

	accel_value_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE1]
		sampleValid && yInRange
			|=> accelWord_r[1][15:2] == $past(accelSamples[2*ACCEL_BITS-1:ACCEL_BITS]))
		else $error("axis sample not placed at bits 15:2");

	// clamped words sit at the ends of the span, sign kept in bits 15 and 14
	accel_clamp_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE2]
		sampleValid && !yInRange
			|=> accelWord_r[1][15:14] == {2{$past(accelSamples[2*ACCEL_BITS-1])}}
			&& accelWord_r[1][13:2] == {(ACCEL_BITS-2){~$past(accelSamples[2*ACCEL_BITS-1])}})
		else $error("out of range axis sample not clamped");

	// one input count stays one count after the host's shift, so the scale holds
	accel_scale_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE4]
		sampleValid && xInRange
			|=> 16'($signed(accelWord_r[0]) >>> ACCEL_LSB_POS)
			== 16'($signed($past(accelSamples[ACCEL_BITS-1:0]))))
		else $error("axis counts changed on the way to the word");

	temp_field_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE5]
		sampleValid |=> tempWord_r[13:1] == $past(tempSample)
			&& tempWord_r[15:14] == 2'h0 && tempWord_r[0] == 1'b0)
		else $error("temperature field misplaced");

	// the held temperature word reaches the bus as it is, with no scaling
	temp_counts_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE7]
		tempHighSeen |=> readValid_r && readData_r == $past(tempWord_r[15:8]))
		else $error("temperature high byte not the held word");

	read_timing_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [RULE2]
		readStrobe && readIndex == ACCEL_Z_HIGH_IDX && !sampleValid
			|=> readValid_r && readData_r == accelWord_r[2][15:8])
		else $error("axis high byte read wrong");

	unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (!rstn) // unmapped
		readStrobe && !indexMapped |=> readValid_r && readData_r == 8'h00)
		else $error("unmapped index not read as zero");

	idle_quiet_a: assert property (@(posedge ref_clk) disable iff (!rstn) // one-cycle answer
		!readStrobe ##1 1'b1 |-> !readValid_r && readData_r == 8'h00)
		else $error("read answer without a strobe");

	// held words move only on a conversion
	words_hold_a: assert property (@(posedge ref_clk) disable iff (!rstn) // word capture
		!sampleValid |=> $stable(tempWord_r) && $stable(accelWord_r[0]))
		else $error("held words moved without a conversion");

	reset_clear_a: assert property (@(posedge ref_clk) // reset state
		!rstn |=> !readValid_r && readData_r == READ_DATA_RST && tempLowLatch_r == TEMP_LATCH_RST)
		else $error("read port not cleared by reset");
endmodule

// ---- verif/atr_host_model.sv ----
`timescale 1ns/100ps
// host side of the byte read port; one read in flight at a time
module atr_host_model (
	input  wire logic       ref_clk,
	input  wire logic [7:0] readData_r,
	input  wire logic       readValid_r,
	output logic            readStrobe,
	output logic [3:0]      readIndex
);
	// idle until the first read
	initial begin
		readStrobe = 1'b0;
		readIndex = 4'h0;
	end

	// one strobe cycle; the answer is taken mid-cycle, once settled
	task automatic read_byte(input logic [3:0] idx, output logic [7:0] d, output logic v);
		@(posedge ref_clk);
		readStrobe <= 1'b1;
		readIndex <= idx;
		@(posedge ref_clk);
		readStrobe <= 1'b0;
		@(negedge ref_clk);
		d = readData_r;
		v = readValid_r;
	endtask

	task automatic read_word(input logic [3:0] hi, output logic [15:0] w, output logic v);
		logic v2;
		read_byte(hi, w[15:8], v);
		read_byte(hi + 4'h1, w[7:0], v2);
		v = v & v2;
	endtask

	// spare bits dropped by the shift
	function automatic logic [15:0] accel_value(input logic [15:0] w);
		return 16'($signed(w) >>> 2);
	endfunction

	function automatic logic [15:0] temp_value(input logic [15:0] w);
		return {3'h0, w[13:1]};
	endfunction
endmodule

// ---- verif/atr_readout_tb.sv ----
`timescale 1ns/100ps
module atr_readout_tb;
	import atr_pkg::*;
	logic        ref_clk      = 1'b0;
	logic        rstn         = 1'b0;
	logic [41:0] accelSamples = 42'h0;
	logic [12:0] tempSample   = 13'h0;
	logic        sampleValid  = 1'b0;
	logic        readStrobe;
	logic [3:0]  readIndex;
	logic [7:0]  readData_r;
	logic        readValid_r;
	logic [7:0]  d;
	logic        v;
	logic [15:0] w;
	logic [13:0] s;
	int          fails        = 0;
	int          checks_done  = 0;
	int          cycles       = 0;

	atr_readout i_dut (.ref_clk(ref_clk), .rstn(rstn), .accelSamples(accelSamples),
		.tempSample(tempSample), .sampleValid(sampleValid), .readStrobe(readStrobe),
		.readIndex(readIndex), .readData_r(readData_r), .readValid_r(readValid_r));
	atr_host_model i_host (.ref_clk(ref_clk), .readData_r(readData_r),
		.readValid_r(readValid_r), .readStrobe(readStrobe), .readIndex(readIndex));

	// 20 MHz clock
	initial forever #25 ref_clk = ~ref_clk;

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// one capture pulse loads every word together
	task automatic load(input logic [41:0] a, input logic [12:0] t);
		@(posedge ref_clk);
		accelSamples <= a;
		tempSample <= t;
		sampleValid <= 1'b1;
		@(posedge ref_clk);
		sampleValid <= 1'b0;
	endtask

	// hang guard, well above the roughly sixty cycles the sequence needs
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fails++;
			give_verdict();
		end
	end

	// main sequence: extremes and the worked example on the axes, latch order on temperature
	initial begin
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		check("reset out", {7'h0, readValid_r, readData_r}, 16'h0000);
		@(posedge ref_clk);
		rstn <= 1'b1;
		i_host.read_byte(TEMP_LOW_IDX, d, v);
		check("unlatched low", {7'h0, v, d}, 16'h0100);
		load({14'h3000, 14'h0FFF, 14'h3EBB}, 13'h101A);
		for (int i = 0; i < 3; i++) begin
			i_host.read_word(4'(2 * i), w, v);
			s = accelSamples[14 * i +: 14];
			check("axis valid", {15'h0, v}, 16'h0001);
			check("axis word", w, {s, 2'b00});
			check("axis value", i_host.accel_value(w), {{2{s[13]}}, s});
		end
		i_host.read_word(ACCEL_X_HIGH_IDX, w, v);
		check("half g", i_host.accel_value(w), 16'(-(ACCEL_COUNTS_PER_G / 2)));
		i_host.read_word(TEMP_HIGH_IDX, w, v);
		check("temp word", w, 16'h2034);
		check("temp counts", i_host.temp_value(w), 16'(TEMP_COUNTS_AT_23C + 26));
		i_host.read_byte(TEMP_HIGH_IDX, d, v);
		load({14'h2000, 14'h1FFF, 14'h3EBB}, 13'h1FFF);
		i_host.read_byte(TEMP_LOW_IDX, d, v);
		check("latched low", {8'h0, d}, 16'h0034);
		i_host.read_word(TEMP_HIGH_IDX, w, v);
		check("new temp", w, 16'h3FFE);
		i_host.read_word(ACCEL_Y_HIGH_IDX, w, v);
		check("clamp high", w, 16'h3FFC);
		i_host.read_word(ACCEL_Z_HIGH_IDX, w, v);
		check("clamp low", w, 16'hC000);
		for (int i = 8; i < 16; i += 7) begin
			i_host.read_byte(4'(i), d, v);
			check("unmapped", {7'h0, v, d}, 16'h0100);
		end
		give_verdict();
	end
endmodule
